// [logic/mpf_pkg.sv]
// Purpose: Shared constants for the port and pin function block
// Assumes: 125 MHz CPU clock, classic Wishbone with 32-bit data
// Notes:   Byte offsets are word aligned; unused bits read zero
// Function
// - Group a input, one pull-up for upper three
// - Group b input, one pull-up, filter bit zero
// - Group c bidirectional, shared timer, clock, tone
// - Group d per-bit direction, one group pull-up
// - Groups e, f pull low only, idle after reset
// - Group g per-bit direction, key returns 0-3
// - Group h key returns 4-7, inputs after reset
// - Group i two bits, one pull-up setting
// - Dual-edge pin requests on both edges
// - Two pins select edge; filter or direct path
// - Rising test pin sets flag, no vector
// - Any key falling edge sets flag only
// - Event input passed on to timer counter
// - Alternate outputs driven when selected and group c set as output
// - Serial pins driven as serial mode requires
// - Sub oscillator pin readable as test bit
// - Pairs e-f and g-h move eight bits
package mpf_pkg;
   // ---------------------------------------------------------------
   // Timing
   // ---------------------------------------------------------------
   localparam int          CLK_MHZ   = 125;
   localparam int          FILT_NS   = 64;
   localparam int          FILT_CYC  = (FILT_NS * CLK_MHZ + 999) / 1000;
   localparam logic [3:0]  FILT_LAST = 4'(FILT_CYC - 1);
   // ---------------------------------------------------------------
   // Synchroniser lanes
   // ---------------------------------------------------------------
   localparam int SYNC_W  = 14;
   localparam int SY_DUAL = 0;
   localparam int SY_FILT = 1;
   localparam int SY_EDGB = 2;
   localparam int SY_RTST = 3;
   localparam int SY_EVT  = 4;
   localparam int SY_KEY  = 5;
   localparam int KEY_W   = 8;
   localparam int SY_SUB  = 13;
   // ---------------------------------------------------------------
   // Register byte offsets
   // ---------------------------------------------------------------
   localparam int          ADR_W = 8;
   localparam logic [7:0]  A_IN  = 8'h00;
   localparam logic [7:0]  A_CD  = 8'h04;
   localparam logic [7:0]  A_EF  = 8'h08;
   localparam logic [7:0]  A_GH  = 8'h0C;
   localparam logic [7:0]  A_I   = 8'h10;
   localparam logic [7:0]  A_DIR = 8'h14;
   localparam logic [7:0]  A_PU  = 8'h18;
   localparam logic [7:0]  A_ALT = 8'h1C;
   localparam logic [7:0]  A_STS = 8'h20;
   localparam logic [7:0]  A_MSK = 8'h24;
   // ---------------------------------------------------------------
   // Field positions
   // ---------------------------------------------------------------
   localparam int DIR_W = 11;
   localparam int DIR_C = 0;
   localparam int DIR_D = 1;
   localparam int DIR_G = 5;
   localparam int DIR_H = 9;
   localparam int DIR_I = 10;
   localparam int PU_W  = 7;
   localparam int ALT_W = 7;
   localparam int ALT_FEN   = 0;
   localparam int ALT_FRISE = 1;
   localparam int ALT_BRISE = 2;
   localparam int ALT_TMRA  = 3;
   localparam int ALT_TMRB  = 4;
   localparam int ALT_PCLK  = 5;
   localparam int ALT_TONE  = 6;
   localparam int ST_W    = 5;
   localparam int ST_DUAL = 0;
   localparam int ST_FILT = 1;
   localparam int ST_EDGB = 2;
   localparam int ST_RTST = 3;
   localparam int ST_KEY  = 4;
endpackage

// [logic/mpf_sync_if.sv]
// Purpose: Carrier between the top and the edge synchroniser
// Assumes: Raw levels are asynchronous to clk_i
// Notes:   Rise and fall are one-cycle pulses
`timescale 1ns/1ps
interface mpf_sync_if;
   logic [mpf_pkg::SYNC_W-1:0] raw;
   logic                       ce;
   logic [mpf_pkg::SYNC_W-1:0] lvl;
   logic [mpf_pkg::SYNC_W-1:0] rise;
   logic [mpf_pkg::SYNC_W-1:0] fall;
   modport det (input raw, input ce, output lvl, output rise,
                output fall);
   modport usr (output raw, output ce, input lvl, input rise,
                input fall);
endinterface

// [logic/mpf_sync.sv]
// Purpose: Two-stage synchroniser and edge detector per lane
// Assumes: ce low freezes every stage
// Notes:   Edge pulses come from the second and third stages
`timescale 1ns/1ps
module mpf_sync
   import mpf_pkg::*;
(
   // Clock and reset
   input  wire logic clk_i,
   input  wire logic rst_n_i,
   // Lanes
   mpf_sync_if.det   sy
);
   typedef struct packed {
      logic [SYNC_W-1:0] s1;
      logic [SYNC_W-1:0] s2;
      logic [SYNC_W-1:0] s3;
      logic [2:0]        warm;
   } mpf_sy_t;

   mpf_sy_t sy_ff;
   mpf_sy_t nxt_sy;

   // ---------------------------------------------------------------
   // Stages
   // ---------------------------------------------------------------
   // First stage feeds only the second, to contain metastability
   always_comb begin
      nxt_sy    = sy_ff;
      nxt_sy.s1 = sy.raw;
      nxt_sy.s2 = sy_ff.s1;
      nxt_sy.s3 = sy_ff.s2;
      // Fills with ones as the three stages take the real pin level
      nxt_sy.warm = 3'((sy_ff.warm << 1) | 3'h1);
   end

   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         sy_ff <= '0;
      end else if (sy.ce) begin
         sy_ff <= nxt_sy;
      end
   end

   // Per-lane edges; a held level yields one pulse only
   // Edges wait for a full pipe, so an idle-high pin gives none at reset
   for (genvar k = 0; k < SYNC_W; k++) begin : g_edge
      assign sy.lvl[k]  = sy_ff.s2[k];
      assign sy.rise[k] = (&sy_ff.warm) & sy_ff.s2[k] & ~sy_ff.s3[k];
      assign sy.fall[k] = (&sy_ff.warm) & ~sy_ff.s2[k] & sy_ff.s3[k];
   end

   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i || !sy.ce);

   a_edge_once: assert property (sy.rise[SY_DUAL] |=> !sy.rise[SY_DUAL])
      else $error("rise pulse lasted more than one cycle");
endmodule

// [logic/mpf_ports.sv]
// Purpose: Port groups, shared pin functions and event flags
// Assumes: Pin inputs synchronous except edge inputs; ce_i gates all
// Notes:   Pin outputs lag register writes by one cycle
`timescale 1ns/1ps
module mpf_ports
   import mpf_pkg::*;
(
   // Clock, reset, enable
   input  wire logic              clk_i,
   input  wire logic              rst_n_i,
   input  wire logic              ce_i,
   // Wishbone slave
   input  wire logic              wb_cyc_i,
   input  wire logic              wb_stb_i,
   input  wire logic              wb_we_i,
   input  wire logic [mpf_pkg::ADR_W-1:0] wb_adr_i,
   input  wire logic [3:0]        wb_sel_i,
   input  wire logic [31:0]       wb_dat_i,
   output logic      [31:0]       wb_dat_o,
   output logic                   wb_ack_o,
   // Interrupts
   output logic                   irq_o,
   output logic      [2:0]        irq_vec_o,
   // Group a and serial pins
   input  wire logic [3:0]        a_in_i,
   output logic      [3:1]        a_out_o,
   output logic      [3:1]        a_oe_o,
   // Group b
   input  wire logic [3:0]        b_in_i,
   // Groups c and d
   input  wire logic [3:0]        c_in_i,
   output logic      [3:0]        c_out_o,
   output logic      [3:0]        c_oe_o,
   input  wire logic [3:0]        d_in_i,
   output logic      [3:0]        d_out_o,
   output logic      [3:0]        d_oe_o,
   // Open-drain groups e and f
   input  wire logic [3:0]        e_in_i,
   output logic      [3:0]        e_out_o,
   output logic      [3:0]        e_oe_o,
   input  wire logic [3:0]        f_in_i,
   output logic      [3:0]        f_out_o,
   output logic      [3:0]        f_oe_o,
   // Groups g, h and i
   input  wire logic [3:0]        g_in_i,
   output logic      [3:0]        g_out_o,
   output logic      [3:0]        g_oe_o,
   input  wire logic [3:0]        h_in_i,
   output logic      [3:0]        h_out_o,
   output logic      [3:0]        h_oe_o,
   input  wire logic [1:0]        i_in_i,
   output logic      [1:0]        i_out_o,
   output logic      [1:0]        i_oe_o,
   // Pull-up enables
   output logic      [mpf_pkg::PU_W-1:0] pu_o,
   // Sub oscillator pin
   input  wire logic              sub_osc_i,
   // Alternate sources
   input  wire logic              tmr_a_i,
   input  wire logic              tmr_b_i,
   input  wire logic              pclk_i,
   input  wire logic              tone_i,
   input  wire logic              ser_sck_out_i,
   input  wire logic              ser_sck_oe_i,
   input  wire logic              ser_so_out_i,
   input  wire logic              ser_so_oe_i,
   input  wire logic              ser_si_out_i,
   input  wire logic              ser_si_oe_i,
   // To internal units
   output logic      [2:0]        ser_pin_o,
   output logic                   evt_count_o
);
   typedef struct packed {
      logic              ack;
      logic [31:0]       rdat;
      logic [7:0]        cd_out;
      logic [7:0]        ef_lo;
      logic [7:0]        gh_out;
      logic [1:0]        i_dat;
      logic [DIR_W-1:0]  dir;
      logic [PU_W-1:0]   pu;
      logic [ALT_W-1:0]  alt;
      logic [ST_W-1:0]   sts;
      logic [ST_W-1:0]   msk;
      logic              filt_lvl;
      logic [3:0]        filt_cnt;
      logic              irq;
      logic [2:0]        vec;
      logic [2:0]        a_o;
      logic [2:0]        a_oe;
      logic [3:0]        c_o;
      logic [3:0]        c_oe;
      logic [3:0]        d_o;
      logic [3:0]        d_oe;
      logic [7:0]        ef_o;
      logic [7:0]        ef_oe;
      logic [3:0]        g_o;
      logic [3:0]        g_oe;
      logic [3:0]        h_o;
      logic [3:0]        h_oe;
      logic [1:0]        i_o;
      logic [1:0]        i_oe;
      logic [2:0]        ser;
      logic              evt;
   } mpf_st_t;

   mpf_st_t         st_ff;
   mpf_st_t         nxt_st;
   logic            req;
   logic            wr;
   logic [ST_W-1:0] set;
   logic [ST_W-1:0] clr;
   logic            f_rise;
   logic            f_fall;
   logic            f_edge;

   // ---------------------------------------------------------------
   // Edge synchroniser
   // ---------------------------------------------------------------
   mpf_sync_if sy ();

   // Lane order follows the sync indices in the package
   assign sy.raw = {sub_osc_i, h_in_i, g_in_i, b_in_i, a_in_i[0]};
   assign sy.ce  = ce_i;

   mpf_sync u_sync (
      .clk_i   (clk_i),
      .rst_n_i (rst_n_i),
      .sy      (sy)
   );

   // ---------------------------------------------------------------
   // Next state
   // ---------------------------------------------------------------
   // One process holds bus, filter, flags and pin drive
   always_comb begin
      nxt_st = st_ff;
      req    = wb_cyc_i & wb_stb_i;
      // Write lands on the edge where the master sees ack
      wr     = req & wb_we_i & st_ff.ack;
      clr    = '0;
      f_rise = 1'b0;
      f_fall = 1'b0;
      nxt_st.ack  = req & ~st_ff.ack;
      nxt_st.rdat = 32'h0;
      if (req && !st_ff.ack) begin
         case (wb_adr_i)
            A_IN:  nxt_st.rdat = {23'h0, sy.lvl[SY_SUB], b_in_i,
                                  a_in_i};
            A_CD:  nxt_st.rdat = {24'h0, d_in_i, c_in_i};
            A_EF:  nxt_st.rdat = {24'h0, f_in_i, e_in_i};
            A_GH:  nxt_st.rdat = {24'h0, h_in_i, g_in_i};
            A_I:   nxt_st.rdat = {30'h0, i_in_i};
            A_DIR: nxt_st.rdat = {21'h0, st_ff.dir};
            A_PU:  nxt_st.rdat = {25'h0, st_ff.pu};
            A_ALT: nxt_st.rdat = {25'h0, st_ff.alt};
            A_STS: nxt_st.rdat = {27'h0, st_ff.sts};
            A_MSK: nxt_st.rdat = {27'h0, st_ff.msk};
            default: nxt_st.rdat = 32'h0;
         endcase
      end
      if (wr && wb_sel_i[0]) begin
         case (wb_adr_i)
            A_CD:  nxt_st.cd_out     = wb_dat_i[7:0];
            A_EF:  nxt_st.ef_lo      = ~wb_dat_i[7:0];
            A_GH:  nxt_st.gh_out     = wb_dat_i[7:0];
            A_I:   nxt_st.i_dat      = wb_dat_i[1:0];
            A_DIR: nxt_st.dir[7:0]   = wb_dat_i[7:0];
            A_PU:  nxt_st.pu         = wb_dat_i[PU_W-1:0];
            A_ALT: nxt_st.alt        = wb_dat_i[ALT_W-1:0];
            A_STS: clr               = wb_dat_i[ST_W-1:0];
            A_MSK: nxt_st.msk        = wb_dat_i[ST_W-1:0];
            default: clr             = '0;
         endcase
      end
      if (wr && wb_sel_i[1] && wb_adr_i == A_DIR) begin
         nxt_st.dir[DIR_W-1:8] = wb_dat_i[DIR_W-1:8];
      end

      // Noise filter: level must differ for FILT_CYC cycles
      if (sy.lvl[SY_FILT] == st_ff.filt_lvl) begin
         nxt_st.filt_cnt = 4'h0;
      end else if (st_ff.filt_cnt == FILT_LAST) begin
         nxt_st.filt_cnt = 4'h0;
         nxt_st.filt_lvl = sy.lvl[SY_FILT];
         f_rise          = sy.lvl[SY_FILT];
         f_fall          = ~sy.lvl[SY_FILT];
      end else begin
         nxt_st.filt_cnt = st_ff.filt_cnt + 4'h1;
      end
      // Filtered path trades latency for glitch immunity
      if (st_ff.alt[ALT_FEN]) begin
         f_edge = st_ff.alt[ALT_FRISE] ? f_rise : f_fall;
      end else begin
         f_edge = st_ff.alt[ALT_FRISE] ? sy.rise[SY_FILT]
                                       : sy.fall[SY_FILT];
      end

      // Event flags
      set          = '0;
      set[ST_DUAL] = sy.rise[SY_DUAL] | sy.fall[SY_DUAL];
      set[ST_FILT] = f_edge;
      set[ST_EDGB] = st_ff.alt[ALT_BRISE] ? sy.rise[SY_EDGB]
                                          : sy.fall[SY_EDGB];
      set[ST_RTST] = sy.rise[SY_RTST];
      set[ST_KEY]  = |sy.fall[SY_KEY +: KEY_W];
      // A new event wins over a clear in the same cycle
      nxt_st.sts = (st_ff.sts & ~clr) | set;
      // Only the three vectored pins raise a request pulse
      nxt_st.vec = set[ST_EDGB:ST_DUAL];
      nxt_st.irq = |(nxt_st.sts & nxt_st.msk);

      // Group c: alternate sources replace the data latch
      nxt_st.c_o[0] = st_ff.alt[ALT_TMRA] ? tmr_a_i
                                          : st_ff.cd_out[0];
      nxt_st.c_o[1] = st_ff.alt[ALT_TMRB] ? tmr_b_i
                                          : st_ff.cd_out[1];
      nxt_st.c_o[2] = st_ff.alt[ALT_PCLK] ? pclk_i
                                          : st_ff.cd_out[2];
      nxt_st.c_o[3] = st_ff.alt[ALT_TONE] ? tone_i
                                          : st_ff.cd_out[3];
      nxt_st.c_oe   = {4{st_ff.dir[DIR_C]}};
      nxt_st.d_o    = st_ff.cd_out[7:4];
      nxt_st.d_oe   = st_ff.dir[DIR_D +: 4];
      // Open drain: only ever pulls low, released after reset
      nxt_st.ef_o   = 8'h00;
      nxt_st.ef_oe  = st_ff.ef_lo;
      nxt_st.g_o    = st_ff.gh_out[3:0];
      nxt_st.g_oe   = st_ff.dir[DIR_G +: 4];
      nxt_st.h_o    = st_ff.gh_out[7:4];
      nxt_st.h_oe   = {4{st_ff.dir[DIR_H]}};
      nxt_st.i_o    = st_ff.i_dat;
      nxt_st.i_oe   = {2{st_ff.dir[DIR_I]}};
      // Serial unit owns drive of the three shared group a pins
      nxt_st.a_o    = {ser_si_out_i, ser_so_out_i, ser_sck_out_i};
      nxt_st.a_oe   = {ser_si_oe_i, ser_so_oe_i, ser_sck_oe_i};
      nxt_st.ser    = a_in_i[3:1];
      nxt_st.evt    = sy.lvl[SY_EVT];
   end

   // ---------------------------------------------------------------
   // State register
   // ---------------------------------------------------------------
   // All-zero reset: inputs only, open drain released, flags clear
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         st_ff <= '0;
      end else if (ce_i) begin
         st_ff <= nxt_st;
      end
   end

   // ---------------------------------------------------------------
   // Outputs
   // ---------------------------------------------------------------
   assign wb_ack_o    = st_ff.ack;
   assign wb_dat_o    = st_ff.rdat;
   assign irq_o       = st_ff.irq;
   assign irq_vec_o   = st_ff.vec;
   assign a_out_o     = st_ff.a_o;
   assign a_oe_o      = st_ff.a_oe;
   assign c_out_o     = st_ff.c_o;
   assign c_oe_o      = st_ff.c_oe;
   assign d_out_o     = st_ff.d_o;
   assign d_oe_o      = st_ff.d_oe;
   assign e_out_o     = st_ff.ef_o[3:0];
   assign e_oe_o      = st_ff.ef_oe[3:0];
   assign f_out_o     = st_ff.ef_o[7:4];
   assign f_oe_o      = st_ff.ef_oe[7:4];
   assign g_out_o     = st_ff.g_o;
   assign g_oe_o      = st_ff.g_oe;
   assign h_out_o     = st_ff.h_o;
   assign h_oe_o      = st_ff.h_oe;
   assign i_out_o     = st_ff.i_o;
   assign i_oe_o      = st_ff.i_oe;
   // One enable per group; bit 0 covers the upper three of group a
   assign pu_o        = st_ff.pu;
   assign ser_pin_o   = st_ff.ser;
   assign evt_count_o = st_ff.evt;

   // ---------------------------------------------------------------
   // Assertions
   // ---------------------------------------------------------------
   default clocking cb @(posedge clk_i); endclocking
   default disable iff (!rst_n_i || !ce_i);

   a_dual_edge_flag: assert property (
      sy.fall[SY_DUAL] |=> st_ff.sts[ST_DUAL] && irq_vec_o[0])
      else $error("dual-edge fall did not flag");
   a_edgb_select: assert property (
      sy.rise[SY_EDGB] && st_ff.alt[ALT_BRISE] |=> irq_vec_o[2])
      else $error("edge pin b rising edge lost");
   a_filt_direct: assert property (
      sy.rise[SY_FILT] && !st_ff.alt[ALT_FEN] && st_ff.alt[ALT_FRISE]
      |=> irq_vec_o[1])
      else $error("direct filtered pin edge lost");
   a_filt_hold: assert property (
      st_ff.alt[ALT_FEN] && !st_ff.filt_lvl && $rose(sy.lvl[SY_FILT])
      |-> !st_ff.filt_lvl [*8])
      else $error("noise filter passed a short pulse");
   a_test_no_vec: assert property (
      sy.rise[SY_RTST] && !(|sy.rise[SY_EDGB:SY_DUAL])
      && !(|sy.fall[SY_EDGB:SY_DUAL]) && !f_edge
      |=> st_ff.sts[ST_RTST] && irq_vec_o == 3'h0)
      else $error("test pin flag wrong or vectored");
   a_key_flag: assert property (
      |sy.fall[SY_KEY +: KEY_W] |=> st_ff.sts[ST_KEY])
      else $error("key return fall did not flag");
   a_evt_pass: assert property (
      evt_count_o == $past(sy.lvl[SY_EVT]))
      else $error("event input not passed to counter");
   a_tone_drive: assert property (
      st_ff.alt[ALT_TONE] && st_ff.dir[DIR_C]
      |=> c_out_o[3] == $past(tone_i) && c_oe_o[3])
      else $error("tone output not driven");
   a_od_release: assert property (
      e_oe_o == 4'h0 || e_out_o == 4'h0)
      else $error("open-drain pin driven high");
   a_ser_drive: assert property (
      ser_sck_oe_i |=> a_oe_o[1] && a_out_o[1] == $past(ser_sck_out_i))
      else $error("serial clock pin not driven");
   a_dir_g_bits: assert property (
      ##1 g_oe_o == $past(st_ff.dir[DIR_G +: 4]))
      else $error("group g direction not per bit");
   a_bus_ack: assert property (
      wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o ##1 !wb_ack_o)
      else $error("wishbone ack not a single cycle");

   c_dual_edge: cover property (sy.rise[SY_DUAL] ##1 st_ff.sts[ST_DUAL]);
   c_key_irq:   cover property (st_ff.sts[ST_KEY] && irq_o);
   c_filt_edge: cover property (st_ff.alt[ALT_FEN] && f_edge);
   c_bus_write: cover property (wr && wb_adr_i == A_EF);
endmodule

// [tb/mpf_board.sv]
// Purpose: Board model for the pins of groups d, e and f
// Assumes: A pull-up is fitted on every open-drain pin
// Notes:   Released pins read high through the pull-up
`timescale 1ns/1ps
module mpf_board (
   // Design side
   input  wire logic [3:0] d_out_i,
   input  wire logic [3:0] d_oe_i,
   input  wire logic [3:0] e_oe_i,
   input  wire logic [3:0] f_oe_i,
   // Board side
   input  wire logic [3:0] d_ext_i,
   output logic      [3:0] d_pin_o,
   output logic      [3:0] e_pin_o,
   output logic      [3:0] f_pin_o
);
   // Open drain only pulls low; the pull-up lifts a released pin
   assign e_pin_o = ~e_oe_i;
   assign f_pin_o = ~f_oe_i;
   // Driven bits show the design level, the rest the board level
   assign d_pin_o = (d_out_i & d_oe_i) | (d_ext_i & ~d_oe_i);
endmodule

// [tb/tb_top.sv]
// Purpose: Directed bench for the port and pin function block
// Assumes: ce_i held high, Wishbone answers within 20 cycles
// Notes:   Edge windows cover sync plus flag latency
`timescale 1ns/1ps
module tb_top;
   import mpf_pkg::*;
   // ------------------------------------------------------------
   // Signals
   // ------------------------------------------------------------
   logic clk_i = 0, rst_n_i = 0, ce_i = 1, sub_osc_i = 0;
   logic wb_cyc_i = 0, wb_stb_i = 0, wb_we_i = 0;
   logic [7:0] wb_adr_i = 0;
   logic [3:0] wb_sel_i = 4'hF;
   logic [31:0] wb_dat_i = 0, wb_dat_o;
   logic wb_ack_o, irq_o, evt_count_o;
   logic [2:0] irq_vec_o, ser_pin_o;
   logic [3:1] a_out_o, a_oe_o;
   logic [3:0] a_in_i = 0, b_in_i = 0, c_in_i = 0, d_ext = 0;
   logic [3:0] g_in_i = 4'hF, h_in_i = 4'hF;
   logic [1:0] i_in_i = 0, i_out_o, i_oe_o;
   logic [3:0] d_in_i, e_in_i, f_in_i, c_out_o, c_oe_o, d_out_o;
   logic [3:0] d_oe_o, e_out_o, e_oe_o, f_out_o, f_oe_o;
   logic [3:0] g_out_o, g_oe_o, h_out_o, h_oe_o;
   logic [6:0] pu_o;
   logic tmr_a_i = 0, tmr_b_i = 0, pclk_i = 0, tone_i = 0;
   logic ser_sck_out_i = 0, ser_sck_oe_i = 0, ser_so_out_i = 0;
   logic ser_so_oe_i = 0, ser_si_out_i = 0, ser_si_oe_i = 0;
   int error_cnt = 0, checks = 0;
   logic [31:0] rd;

   mpf_ports u_dut (.*);
   mpf_board u_board (.d_out_i(d_out_o), .d_oe_i(d_oe_o),
      .e_oe_i(e_oe_o), .f_oe_i(f_oe_o), .d_ext_i(d_ext),
      .d_pin_o(d_in_i), .e_pin_o(e_in_i), .f_pin_o(f_in_i));

   // 125 MHz clock
   always #4 clk_i = ~clk_i;

   // ------------------------------------------------------------
   // Bus and compare tasks
   // ------------------------------------------------------------
   task automatic chk(input logic [31:0] got, input logic [31:0] exp);
      checks++;
      if (got !== exp) begin
         error_cnt++;
         $display("unexpected at %0t: got %h want %h", $time, got, exp);
      end
   endtask
   // Classic cycle: hold the request until ack is sampled high
   task automatic wb(input logic we, input logic [7:0] a,
                     input logic [31:0] d, output logic [31:0] q);
      int n;
      n = 0;
      @(posedge clk_i);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= {2'b11, we};
      wb_adr_i <= a;
      wb_dat_i <= d;
      do begin
         @(posedge clk_i);
         n++;
      end while (wb_ack_o !== 1'b1 && n < 20);
      q = wb_dat_o;
      if (n >= 20) chk(32'h0, 32'h1);
      {wb_cyc_i, wb_stb_i, wb_we_i} <= 3'b000;
   endtask
   task automatic wr(input logic [7:0] a, input logic [31:0] d);
      logic [31:0] q;
      wb(1'b1, a, d, q);
   endtask
   task automatic wait_n(input int n);
      repeat (n) @(posedge clk_i);
   endtask
   // Collect flags for a window, compare, then clear by writing ones
   task automatic chk_ev(input logic [4:0] es, input logic [2:0] ev,
                         input logic ei);
      logic [2:0] v;
      v = 0;
      repeat (16) begin
         @(posedge clk_i);
         v = v | irq_vec_o;
      end
      chk(32'(irq_o), 32'(ei));
      wb(1'b0, A_STS, 0, rd);
      chk(rd, 32'(es));
      chk(32'(v), 32'(ev));
      wr(A_STS, 32'h1F);
      wait_n(2);
      chk(32'(irq_o), 0);
   endtask
   task automatic test_done;
      $display("checks %0d errors %0d", checks, error_cnt);
      if (error_cnt == 0 && checks > 0)
         $display("TB: PASS");
      else
         $display("TB: FAIL");
      $finish;
   endtask

   // ------------------------------------------------------------
   // Scenarios
   // ------------------------------------------------------------
   task automatic t_reset;
      chk({d_oe_o, c_oe_o, e_oe_o, f_oe_o}, 0);
      chk({g_oe_o, h_oe_o, i_oe_o, pu_o, irq_o}, 0);
      wb(1'b0, A_EF, 0, rd);
      chk(rd, 32'hFF);
      wb(1'b0, A_DIR, 0, rd);
      chk(rd, 0);
      wb(1'b0, 8'h40, 0, rd);
      chk(rd, 0);
      $display("t_reset done");
   endtask
   task automatic t_ports;
      wr(A_DIR, 32'h6AA);
      wr(A_GH, 32'h3C);
      wr(A_CD, 32'hF0);
      wr(A_EF, 32'h5A);
      wr(A_PU, 32'h7F);
      wr(A_I, 32'h2);
      wait_n(2);
      chk(32'(d_oe_o), 32'h5);
      chk({g_oe_o, h_oe_o}, 8'h5F);
      chk({h_out_o, g_out_o, f_out_o}, 12'h3C0);
      wb(1'b0, A_CD, 0, rd);
      chk(rd, 32'h50);
      chk({e_oe_o, f_oe_o, e_out_o}, 12'h5A0);
      wb(1'b0, A_EF, 0, rd);
      chk(rd, 32'h5A);
      chk(32'(pu_o), 32'h7F);
      chk({i_oe_o, i_out_o}, 4'hE);
      $display("t_ports done");
   endtask
   task automatic t_alt;
      wr(A_DIR, 32'h1);
      wr(A_ALT, 32'h78);
      tmr_a_i <= 1;
      pclk_i <= 1;
      tone_i <= 1;
      {ser_sck_oe_i, ser_sck_out_i} <= 2'b11;
      a_in_i[3:1] <= 3'b101;
      b_in_i[3] <= 1;
      sub_osc_i <= 1;
      wait_n(6);
      chk({c_oe_o, c_out_o}, 8'hFD);
      chk({a_oe_o[1], a_out_o[1], ser_pin_o}, 5'h1D);
      chk(32'(evt_count_o), 1);
      wb(1'b0, A_IN, 0, rd);
      chk(rd & 32'h1FF, 32'h18A);
      $display("t_alt done");
   endtask
   task automatic t_edges;
      wr(A_MSK, 32'h1F);
      wr(A_ALT, 32'h2);
      a_in_i[0] <= 1;
      chk_ev(5'h01, 3'h1, 1);
      a_in_i[0] <= 0;
      chk_ev(5'h01, 3'h1, 1);
      b_in_i[0] <= 1;
      chk_ev(5'h02, 3'h2, 1);
      b_in_i[1] <= 1;
      chk_ev(5'h00, 3'h0, 0);
      b_in_i[1] <= 0;
      chk_ev(5'h04, 3'h4, 1);
      b_in_i[2] <= 1;
      chk_ev(5'h08, 3'h0, 1);
      b_in_i[2] <= 0;
      chk_ev(5'h00, 3'h0, 0);
      g_in_i[0] <= 0;
      chk_ev(5'h10, 3'h0, 1);
      wr(A_MSK, 32'h0);
      h_in_i[3] <= 0;
      chk_ev(5'h10, 3'h0, 0);
      // Short pulse on the filtered pin must be dropped
      wr(A_ALT, 32'h3);
      b_in_i[0] <= 0;
      chk_ev(5'h00, 3'h0, 0);
      b_in_i[0] <= 1;
      wait_n(3);
      b_in_i[0] <= 0;
      chk_ev(5'h00, 3'h0, 0);
      // Long level passes the filter; edge pin b now on rising edge
      wr(A_ALT, 32'h7);
      b_in_i[0] <= 1;
      b_in_i[1] <= 1;
      chk_ev(5'h06, 3'h6, 0);
      $display("t_edges done");
   endtask

   // ------------------------------------------------------------
   // Main sequence and watchdog
   // ------------------------------------------------------------
   initial begin
      wait_n(4);
      rst_n_i <= 1;
      t_reset();
      t_ports();
      t_alt();
      t_edges();
      test_done();
   end
   initial begin
      #100us;
      error_cnt++;
      test_done();
   end
endmodule
